// file: rtl/arp_cfg.svh
`ifndef ARP_CFG_SVH
`define ARP_CFG_SVH

// Register address map, five address lines
`define ARP_ADDR_FIFO      5'h08
`define ARP_IDX_IN_LAST    4'h3
`define ARP_IDX_OUT_FIRST  4'h4
`define ARP_IDX_OUT_LAST   4'h7
`define ARP_IDX_PT_ADDR    4'h9
`define ARP_IDX_BM_RD_ADDR 4'hA
`define ARP_IDX_INT_CTRL   4'hB
`define ARP_IDX_GEN_CTRL   4'hC

// Reset values and the all-lanes mask
`define ARP_WORD_ZERO      32'h0000_0000
`define ARP_ADDR_ZERO      5'h00
`define ARP_CTRL_IDLE      7'h7F
`define ARP_LANES_NONE     4'h0
`define ARP_LANES_ALL      4'hF

`endif

// file: rtl/arp_pkg.sv
`default_nettype none
package arp_pkg;
    typedef logic [31:0] arp_word_t;
    typedef logic [3:0]  arp_lanes_t;
    typedef logic [3:0]  arp_idx_t;
endpackage
`default_nettype wire

// file: rtl/arp_port.sv
// Overview of operation
// [RULE1] 16-bit mode uses only low sixteen lines
// [RULE2] Five address lines pick one of sixteen
// [RULE3] Mailboxes, addresses, interrupt and general control
// [RULE4] Top lane enable becomes address bit one
// [RULE5] Top byte written only with its enable
// [RULE6] Top byte driven only with its enable
// [RULE7] Each lower enable governs its byte
// [RULE8] Reads drive only enabled lower lanes
// [RULE9] Writes modify only enabled bytes
// [RULE10] Other side holds select low per access
// [RULE11] Other side keeps select steady during strobes
// [RULE12] Write strobe plus select writes register
// [RULE13] Read strobe plus select reads register
// [RULE14] Width input low 32-bit, high 16-bit
// [RULE15] Address 01000b is the FIFO port
// [RULE16] Bus released whenever no selected read
`include "arp_cfg.svh"
`default_nettype none
module arp_port (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Add-on register access pins
    input  wire logic [31:0] dq_i,
    output logic      [31:0] dq_o,
    output logic      [3:0]  dq_oe_o,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic        top_byte_lane_enable_n_i,
    input  wire logic [2:0]  lower_byte_lane_enables_n_i,
    input  wire logic        select_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        width_sel_i,
    // Core side incoming mailbox load
    input  wire logic        core_mbox_we_i,
    input  wire logic [1:0]  core_mbox_idx_i,
    input  wire logic [31:0] core_mbox_data_i,
    // Core side FIFO port
    input  wire logic [31:0] fifo_rdata_i,
    output logic             fifo_rd_o,
    output logic             fifo_wr_o,
    output logic      [31:0] fifo_wdata_o,
    output logic      [3:0]  fifo_be_o
);
    // Two-stage synchronisers for every add-on access pin
    logic [37:0] dat_s1_reg, dat_s2_reg;
    logic [6:0]  ctl_s1_reg, ctl_s2_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dat_s1_reg <= {`ARP_WORD_ZERO, `ARP_ADDR_ZERO, 1'b0};
            dat_s2_reg <= {`ARP_WORD_ZERO, `ARP_ADDR_ZERO, 1'b0};
            ctl_s1_reg <= `ARP_CTRL_IDLE;
            ctl_s2_reg <= `ARP_CTRL_IDLE;
        end else begin
            dat_s1_reg <= {dq_i, reg_addr_i, width_sel_i};
            dat_s2_reg <= dat_s1_reg;
            ctl_s1_reg <= {top_byte_lane_enable_n_i,
                           lower_byte_lane_enables_n_i,
                           select_n_i, wr_n_i, rd_n_i};
            ctl_s2_reg <= ctl_s1_reg;
        end
    end

    logic [31:0] dq_s;
    logic [4:0]  addr_s;
    logic        mode16_s, be3n_s, seln_s, wrn_s, rdn_s;
    logic [2:0]  ben_s;
    assign {dq_s, addr_s, mode16_s}               = dat_s2_reg;
    assign {be3n_s, ben_s, seln_s, wrn_s, rdn_s}  = ctl_s2_reg;

    // Access decode
    arp_pkg::arp_idx_t   idx;
    arp_pkg::arp_lanes_t mem_be, pin_lanes;
    arp_pkg::arp_word_t  wdata;
    logic wr_act, rd_act, wr_start, rd_start;
    logic mapped, writable, fifo_sel, mem_we;
    logic wr_prev_reg, rd_prev_reg;

    always_comb begin
        idx      = addr_s[3:0];
        wr_act   = !seln_s && !wrn_s;                  // RULE12
        rd_act   = !seln_s && !rdn_s;                  // RULE13
        wr_start = wr_act && !wr_prev_reg;
        rd_start = rd_act && !rd_prev_reg;
        // Upper address half holds nothing
        mapped   = !addr_s[4] && idx <= `ARP_IDX_GEN_CTRL;      // RULE2
        fifo_sel = addr_s == `ARP_ADDR_FIFO;                     // RULE15
        // Incoming mailboxes are read-only from this side
        writable = mapped && !fifo_sel && idx > `ARP_IDX_IN_LAST; // RULE3
        if (mode16_s) begin                                       // RULE14
            // Top lane enable pin now picks the half word
            mem_be    = be3n_s ? {~ben_s[1:0], 2'b00}
                               : {2'b00, ~ben_s[1:0]};            // RULE4
            pin_lanes = {2'b00, ~ben_s[1:0]};                     // RULE1
            wdata     = {dq_s[15:0], dq_s[15:0]};
        end else begin
            mem_be    = {~be3n_s, ~ben_s};                   // RULE5 RULE7
            pin_lanes = {~be3n_s, ~ben_s};
            wdata     = dq_s;
        end
        mem_we = wr_start && writable;                       // RULE9
    end

    // Read pipeline stage aligned with memory read data
    logic                rq_act_reg, rq_mode16_reg, rq_half_reg;
    logic                rq_fifo_reg, rq_mapped_reg;
    arp_pkg::arp_lanes_t rq_lanes_reg;
    logic                rq_act_next, rq_mode16_next, rq_half_next;
    logic                rq_fifo_next, rq_mapped_next;
    arp_pkg::arp_lanes_t rq_lanes_next;

    always_comb begin
        rq_act_next    = rd_act;
        rq_mode16_next = mode16_s;
        rq_half_next   = be3n_s;
        rq_fifo_next   = fifo_sel;
        rq_mapped_next = mapped;
        rq_lanes_next  = pin_lanes;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_prev_reg   <= 1'b0;
            rd_prev_reg   <= 1'b0;
            rq_act_reg    <= 1'b0;
            rq_mode16_reg <= 1'b0;
            rq_half_reg   <= 1'b0;
            rq_fifo_reg   <= 1'b0;
            rq_mapped_reg <= 1'b0;
            rq_lanes_reg  <= `ARP_LANES_NONE;
        end else begin
            wr_prev_reg   <= wr_act;
            rd_prev_reg   <= rd_act;
            rq_act_reg    <= rq_act_next;
            rq_mode16_reg <= rq_mode16_next;
            rq_half_reg   <= rq_half_next;
            rq_fifo_reg   <= rq_fifo_next;
            rq_mapped_reg <= rq_mapped_next;
            rq_lanes_reg  <= rq_lanes_next;
        end
    end

    arp_pkg::arp_word_t mem_rdata;

    arp_regmem #(
        .WIDTH (32),
        .DEPTH (16),
        .AW    (4)
    ) u_regmem (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .a_we_i    (mem_we),
        .a_idx_i   (idx),
        .a_be_i    (mem_be),
        .a_wdata_i (wdata),
        .b_we_i    (core_mbox_we_i),
        .b_idx_i   ({2'b00, core_mbox_idx_i}),
        .b_wdata_i (core_mbox_data_i),
        .rd_idx_i  (idx),
        .rd_data_o (mem_rdata)
    );

    // Output stage: data and per-lane drive
    arp_pkg::arp_word_t  word, dq_next, fifo_wdata_next;
    arp_pkg::arp_lanes_t oe_next, fifo_be_next;
    logic                fifo_rd_next, fifo_wr_next;

    always_comb begin
        if (rq_fifo_reg) begin
            word = fifo_rdata_i;
        end else if (rq_mapped_reg) begin
            word = mem_rdata;
        end else begin
            word = `ARP_WORD_ZERO;
        end
        if (rq_mode16_reg) begin
            dq_next = {16'h0000, rq_half_reg ? word[31:16] : word[15:0]};
        end else begin
            dq_next = word;
        end
        // Drop drive on the next clock after the synchronised read strobe goes away
        oe_next = (rq_act_reg && rd_act) ? rq_lanes_reg // RULE6 RULE8
                                         : `ARP_LANES_NONE; // RULE16
        fifo_rd_next    = rd_start && fifo_sel;
        fifo_wr_next    = wr_start && fifo_sel;
        fifo_wdata_next = wdata;
        fifo_be_next    = mem_be;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dq_o         <= `ARP_WORD_ZERO;
            dq_oe_o      <= `ARP_LANES_NONE;
            fifo_rd_o    <= 1'b0;
            fifo_wr_o    <= 1'b0;
            fifo_wdata_o <= `ARP_WORD_ZERO;
            fifo_be_o    <= `ARP_LANES_NONE;
        end else begin
            dq_o         <= dq_next;
            dq_oe_o      <= oe_next;
            fifo_rd_o    <= fifo_rd_next;
            fifo_wr_o    <= fifo_wr_next;
            fifo_wdata_o <= fifo_wdata_next;
            fifo_be_o    <= fifo_be_next;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_half_upper_off: assert property ( // RULE1
        rq_act_reg && rq_mode16_reg |=> dq_oe_o[3:2] == 2'b00)
        else $error("upper lanes driven in 16-bit mode");
    a_full_width_read: assert property ( // RULE14
        rd_act && $past(rd_act) && !rq_mode16_reg &&
        rq_lanes_reg == `ARP_LANES_ALL |=> dq_oe_o == `ARP_LANES_ALL)
        else $error("32-bit read not driven on all lanes");
    a_top_lane_write: assert property ( // RULE5
        mem_we && !mode16_s && be3n_s |-> !mem_be[3])
        else $error("top byte written without its enable");
    a_top_lane_read: assert property ( // RULE6
        dq_oe_o[3] |-> $past(rq_lanes_reg[3]) && $past(rd_act))
        else $error("top lane driven without enable");
    a_lower_lane_read: assert property ( // RULE8
        (dq_oe_o[2:0] & ~$past(rq_lanes_reg[2:0])) == 3'b000)
        else $error("lower lane driven without enable");
    a_write_lane_map: assert property ( // RULE9
        wr_start && !mode16_s |-> mem_be == ~{be3n_s, ben_s})
        else $error("write lanes do not follow enables");
    a_half_addr_bit: assert property ( // RULE4
        wr_start && mode16_s && be3n_s |-> mem_be[1:0] == 2'b00)
        else $error("upper half write touched low half");
    a_fifo_decode: assert property ( // RULE15
        fifo_wr_o || fifo_rd_o |-> $past(addr_s) == `ARP_ADDR_FIFO)
        else $error("FIFO strobe for wrong address");
    a_bus_release: assert property ( // RULE16
        !rd_act |=> dq_oe_o == `ARP_LANES_NONE)
        else $error("bus driven without selected read");
    a_in_mbox_ro: assert property ( // RULE3
        mem_we |-> idx > `ARP_IDX_IN_LAST && !fifo_sel && !addr_s[4])
        else $error("write to read-only or unmapped entry");
    a_fifo_rd_once: assert property ( // RULE13
        fifo_rd_o |=> !fifo_rd_o [*2])
        else $error("FIFO read pulse repeated");

    c_full_read:   cover property (dq_oe_o == `ARP_LANES_ALL);
    c_half_read:   cover property (rq_act_reg && rq_mode16_reg && rq_half_reg);
    c_fifo_write:  cover property (fifo_wr_o);
    c_mbox_write:  cover property (mem_we && idx == `ARP_IDX_OUT_FIRST);
endmodule
`default_nettype wire

// file: rtl/arp_regmem.sv
`default_nettype none
module arp_regmem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    // Byte-lane write port, add-on side
    input  wire logic                 a_we_i,
    input  wire logic [AW-1:0]        a_idx_i,
    input  wire logic [WIDTH/8-1:0]   a_be_i,
    input  wire logic [WIDTH-1:0]     a_wdata_i,
    // Whole-word write port, core side
    input  wire logic                 b_we_i,
    input  wire logic [AW-1:0]        b_idx_i,
    input  wire logic [WIDTH-1:0]     b_wdata_i,
    // Read port
    input  wire logic [AW-1:0]        rd_idx_i,
    output logic      [WIDTH-1:0]     rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Ports A and B never target one entry; A wins if misused
    for (genvar e = 0; e < DEPTH; e++) begin : g_entry
        logic a_hit;
        logic b_hit;
        assign a_hit = a_we_i && a_idx_i == AW'(e);
        assign b_hit = b_we_i && b_idx_i == AW'(e) && !a_hit;
        for (genvar g = 0; g < WIDTH / 8; g++) begin : g_lane
            always_ff @(posedge clk_i) begin
                if (a_hit && a_be_i[g]) begin
                    mem[e][8*g +: 8] <= a_wdata_i[8*g +: 8];
                end else if (b_hit) begin
                    mem[e][8*g +: 8] <= b_wdata_i[8*g +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem[rd_idx_i];
        end
    end
endmodule
`default_nettype wire

// file: test/arp_addon_model.sv
`default_nettype none
module arp_addon_model (
    // Clock and resolved bus
    input  wire logic        clk_i,
    input  wire logic [31:0] bus_i,
    input  wire logic [3:0]  oe_i,
    // Pins toward the port
    output logic      [4:0]  adr_o,
    output logic      [3:0]  en_n_o,
    output logic             sel_n_o,
    output logic             wr_n_o,
    output logic             rd_n_o,
    output logic             wid_o,
    output logic      [31:0] dq_o,
    output logic             dq_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {adr_o, en_n_o, wid_o, dq_o, dq_en_o} = '0;
        {sel_n_o, wr_n_o, rd_n_o} = 3'h7;
    end
    // Qualifiers settle three clocks ahead of the strobe
    task automatic setup(input logic [4:0] a, input logic [3:0] e,
                         input logic m, input logic [31:0] d,
                         input logic drv);
        @(posedge clk_i);
        adr_o   <= a;
        en_n_o  <= e;
        wid_o   <= m;
        dq_o    <= d;
        dq_en_o <= drv;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wr_acc(input logic [4:0] a, input logic [3:0] e,
                          input logic m, input logic [31:0] d);
        setup(a, e, m, d, 1'b1);
        sel_n_o <= 1'b0;
        wr_n_o  <= 1'b0;
        repeat (4) @(posedge clk_i);
        sel_n_o <= 1'b1;
        wr_n_o  <= 1'b1;
        // Data outlives the synchronised strobe
        repeat (3) @(posedge clk_i);
        dq_en_o <= 1'b0;
    endtask
    task automatic rd_acc(input logic [4:0] a, input logic [3:0] e,
                          input logic m, output logic [31:0] q,
                          output logic [3:0] oe, output logic [3:0] oe_end);
        setup(a, e, m, 32'h0000_0000, 1'b0);
        sel_n_o <= 1'b0;
        rd_n_o  <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        q  = bus_i;
        oe = oe_i;
        @(posedge clk_i);
        sel_n_o <= 1'b1;
        rd_n_o  <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        oe_end = oe_i;
    endtask
endmodule
`default_nettype wire

// file: test/test_add_on_register_access_port.sv
`default_nettype none
module test_add_on_register_access_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] HEAD = 32'hF1F0_C0DE;
    logic        clk_i;
    logic        arst_n_i;
    logic [31:0] dq_q, pm_q, bus, q, fw_data;
    logic [3:0]  dq_oe, en_n, oe, oe_end, fw_be, fbe_seen;
    logic [4:0]  adr;
    logic        sel_n, wr_n, rd_n, wid, pm_en, mb_we, f_rd, f_wr;
    logic [1:0]  mb_idx;
    logic [31:0] mb_data;
    int          err_count, comparisons, rd_cnt, wr_cnt;
    logic [31:0] shadow [16];
    arp_addon_model pm (.clk_i(clk_i), .bus_i(bus), .oe_i(dq_oe),
        .adr_o(adr), .en_n_o(en_n), .sel_n_o(sel_n), .wr_n_o(wr_n),
        .rd_n_o(rd_n), .wid_o(wid), .dq_o(pm_q), .dq_en_o(pm_en));
    arp_port dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .dq_i(bus),
        .dq_o(dq_q), .dq_oe_o(dq_oe), .reg_addr_i(adr),
        .top_byte_lane_enable_n_i(en_n[3]),
        .lower_byte_lane_enables_n_i(en_n[2:0]), .select_n_i(sel_n),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .width_sel_i(wid),
        .core_mbox_we_i(mb_we), .core_mbox_idx_i(mb_idx),
        .core_mbox_data_i(mb_data), .fifo_rdata_i(HEAD),
        .fifo_rd_o(f_rd), .fifo_wr_o(f_wr), .fifo_wdata_o(fw_data),
        .fifo_be_o(fw_be));
    // Pull-ups win wherever nobody drives a lane
    for (genvar n = 0; n < 4; n++) begin : g_lane
        assign bus[8*n+:8] = dq_oe[n] ? dq_q[8*n+:8]
                           : pm_en ? pm_q[8*n+:8] : 8'hFF;
    end
    always @(posedge clk_i) begin
        if (f_rd === 1'b1) rd_cnt++;
        if (f_wr === 1'b1) begin
            wr_cnt++;
            shadow[8] <= fw_data;
            fbe_seen  <= fw_be;
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] lanes(input logic [31:0] v,
        input logic [31:0] d, input logic [3:0] e);
        for (int n = 0; n < 4; n++)
            if (e[n]) v[8*n+:8] = d[8*n+:8];
        return v;
    endfunction
    task automatic rd(input logic [4:0] a, input logic [3:0] e,
                      input logic m);
        pm.rd_acc(a, e, m, q, oe, oe_end);
        check("oe_end", 32'(oe_end), 32'h0000_0000);
    endtask
    task automatic t_rw32();
        for (int i = 4; i < 13; i++) begin
            shadow[i] = 32'h1357_9BDF ^ {8{4'(i)}};
            if (i != 8) pm.wr_acc(5'(i), 4'h0, 1'b0, shadow[i]);
        end
        for (int i = 4; i < 13; i++) begin
            if (i == 8) continue;
            rd(5'(i), 4'h0, 1'b0);
            check("reg", q, shadow[i]);
            check("oe", 32'(oe), 32'h0000_000F);
        end
        $display("rw32 done");
    endtask
    task automatic t_lanes();
        pm.wr_acc(5'h05, 4'h7, 1'b0, 32'hDEAD_BEEF);
        shadow[5] = lanes(32'hDEAD_BEEF, shadow[5], 4'h7);
        pm.wr_acc(5'h05, 4'hE, 1'b0, 32'h0BAD_F00D);
        shadow[5] = lanes(32'h0BAD_F00D, shadow[5], 4'hE);
        rd(5'h05, 4'h5, 1'b0);
        check("lane", q, lanes(shadow[5], 32'hFFFF_FFFF, 4'h5));
        check("lane_oe", 32'(oe), 32'h0000_000A);
        $display("lanes done");
    endtask
    task automatic t_refused();
        @(posedge clk_i);
        {mb_we, mb_idx, mb_data} <= {1'b1, 2'h2, 32'h2468_ACE0};
        @(posedge clk_i);
        mb_we <= 1'b0;
        pm.wr_acc(5'h02, 4'h0, 1'b0, 32'h5555_0000);
        rd(5'h02, 4'h0, 1'b0);
        check("in_mbox", q, 32'h2468_ACE0);
        rd(5'h0D, 4'h0, 1'b0);
        check("reserved", q, 32'h0000_0000);
        rd(5'h15, 4'h0, 1'b0);
        check("high_adr", q, 32'h0000_0000);
        $display("refused done");
    endtask
    task automatic t_mode16();
        pm.wr_acc(5'h06, 4'hC, 1'b1, 32'h5A5A_CAFE);
        pm.wr_acc(5'h06, 4'h6, 1'b1, 32'hA5A5_0077);
        shadow[6] = {16'hCAFE, shadow[6][15:8], 8'h77};
        rd(5'h06, 4'h0, 1'b0);
        check("mode32", q, shadow[6]);
        rd(5'h06, 4'hC, 1'b1);
        check("mode16", q, 32'hFFFF_CAFE);
        check("oe16", 32'(oe), 32'h0000_0003);
        $display("mode16 done");
    endtask
    task automatic t_fifo();
        pm.wr_acc(5'h08, 4'h0, 1'b0, 32'h600D_F1F0);
        check("fifo_wr", 32'(wr_cnt), 32'h0000_0001);
        check("fifo_wdata", shadow[8], 32'h600D_F1F0);
        check("fifo_be", 32'(fbe_seen), 32'h0000_000F);
        rd(5'h08, 4'h0, 1'b0);
        check("fifo_rd", 32'(rd_cnt), 32'h0000_0001);
        check("fifo_head", q, HEAD);
        $display("fifo done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {arst_n_i, mb_we, mb_idx, mb_data} = '0;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_rw32();
        t_lanes();
        t_refused();
        t_mode16();
        t_fifo();
        summarize();
    end
    // Watchdog against a hung access
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        $display("[ERR] watchdog expected done seen hang");
        summarize();
    end
endmodule
`default_nettype wire
